// ===== verilog/bbc_pkg.sv
package bbc_pkg;
  localparam logic [7:0] REG_MODE = 8'h02;
  localparam logic [7:0] REG_POL  = 8'h03;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int B_FPWM  = 0;
  localparam int B_RISE  = 1;
  localparam int B_FALL  = 2;
  localparam int B_DIS   = 3;
  localparam int B_UMODE = 6;
  localparam int B_OCP   = 0;
  localparam int B_POL   = 4;
  localparam int B_EN    = 6;
  localparam int S_PG    = 0;
  localparam int S_SS    = 1;
  localparam int S_HIC   = 2;
  localparam int S_TSD   = 3;
  localparam int S_UV    = 4;
  localparam int S_OC    = 5;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] POL_RST  = 8'h40;
  localparam logic [7:0] ZERO8    = 8'h00;
  // Arbitrary bus address
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h2a;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [1:0] STRAP_HOLD = 2'h3;
  localparam int CLK_MHZ   = 100;
  localparam int T_IDLE_NS = 37000;
  localparam int T_USP_NS  = 50;
  localparam int T_OCF_NS  = 100;
  localparam int T_PGF_NS  = 3000;
  localparam int T_PGR_US  = 1500;
  localparam int T_HIC_US  = 15000;
  localparam int OC_CYCLES = 17;
  localparam int C_IDLE = (T_IDLE_NS * CLK_MHZ + 999) / 1000;
  localparam int C_USP  = (T_USP_NS * CLK_MHZ) / 1000;
  localparam int C_OCF  = (T_OCF_NS * CLK_MHZ + 999) / 1000;
  localparam int C_PGF  = (T_PGF_NS * CLK_MHZ + 999) / 1000;
  localparam int C_PGR  = T_PGR_US * CLK_MHZ;
  localparam int C_HIC  = T_HIC_US * CLK_MHZ;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_PTR  = 5'h04,
    ST_WR   = 5'h08,
    ST_RD   = 5'h10
  } bbc_ser_t;
endpackage

// ===== verilog/bbc_top.sv
`timescale 1ns/1ns
`default_nettype none
module bbc_top #(
  parameter logic [6:0] SLAVE_ADDR  = bbc_pkg::SLAVE_ADDR_DEF,
  parameter int         PG_RISE_CYC = bbc_pkg::C_PGR,
  parameter int         HICCUP_CYC  = bbc_pkg::C_HIC
) (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic chip_enable,
  input  wire logic mode_strap,
  input  wire logic overcurrent_select_strap,
  input  wire logic uvlo_flag,
  input  wire logic over_temp,
  input  wire logic oc_trip,
  input  wire logic reverse_trip,
  input  wire logic feedback_sense,
  input  wire logic vout_above_80,
  input  wire logic vout_below_20,
  input  wire logic vout_at_target,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic switch_event,
  input  wire logic cycle_start,
  input  wire logic boost_active,
  input  wire logic buck_high_req,
  input  wire logic buck_low_req,
  input  wire logic boost_output_req,
  input  wire logic boost_ground_req,
  output logic      sda_o,
  output logic      sda_oe,
  output logic      power_good_out,
  output logic      power_good_oe,
  output logic      buck_high_switch,
  output logic      buck_low_switch,
  output logic      boost_output_switch,
  output logic      boost_ground_switch,
  output logic      regulator_on,
  output logic      soft_start_active,
  output logic      forced_pwm_active,
  output logic      ultrasonic_active,
  output logic      freq_reduce,
  output logic      hiccup_active,
  output logic      ocp_threshold_high,
  output logic      rise_rate_select,
  output logic      fall_rate_select,
  output logic      discharge_on
);
  import bbc_pkg::*;

  localparam int NSYNC = 13;
  // One counter times both delays, so it must hold the longer one
  localparam int PGMAX = (PG_RISE_CYC > C_PGF) ? PG_RISE_CYC : C_PGF;
  localparam int PGW   = $clog2(PGMAX + 1);
  localparam logic [NSYNC-1:0] SY_IDLE = {2'b11, {(NSYNC-2){1'b0}}};
  localparam int HCW   = $clog2(HICCUP_CYC + 1);
  localparam int IDW   = $clog2(C_IDLE + 1);
  localparam int UPW   = $clog2(C_USP + 1);
  localparam int OFW   = $clog2(C_OCF + 1);
  localparam int OCW   = $clog2(OC_CYCLES + 1);

  logic [NSYNC-1:0] sy1_q;
  logic [NSYNC-1:0] sy2_q;
  logic             scl_s;
  logic             sda_s;
  logic             mode_s;
  logic             ocps_s;
  logic             ce_s;
  logic             uv_s;
  logic             ot_s;
  logic             oct_s;
  logic             rev_s;
  logic             fb_s;
  logic             a80_s;
  logic             b20_s;
  logic             tgt_s;
  logic             scl_d_q;
  logic             sda_d_q;
  logic             scl_rise;
  logic             scl_fall;
  logic             bus_start;
  logic             bus_stop;
  logic [1:0]       load_q;
  logic             defaults;
  logic [7:0]       mode_q;
  logic [7:0]       pol_q;
  logic [7:0]       stat;
  logic [7:0]       rd_byte;
  logic [7:0]       rd_ptr;
  bbc_ser_t         st_q;
  logic [3:0]       cnt_q;
  logic             ackph_q;
  logic [7:0]       sr_q;
  logic [7:0]       tx_q;
  logic [7:0]       ptr_q;
  logic             mack_q;
  logic             sda_oe_q;
  logic             wr_stb;
  logic             run_en;
  logic             run;
  logic             us_mode;
  logic             ss_q;
  logic             pg_q;
  logic [PGW-1:0]   pgc_q;
  logic [PGW-1:0]   pg_lim;
  logic             pg_oe_q;
  logic             oc_q;
  logic [OFW-1:0]   ocf_q;
  logic             oc_seen_q;
  logic [OCW-1:0]   occ_q;
  logic             hic_q;
  logic [HCW-1:0]   hcnt_q;
  logic             rev_blk_q;
  logic [IDW-1:0]   idc_q;
  logic [UPW-1:0]   upc_q;
  logic             usp_q;

  // Status, strap and bus inputs pass two flops; switch_event, cycle_start, boost_active and the requests do not
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      // Bus lines start at their idle high level so no false edge follows reset
      sy1_q <= SY_IDLE;
      sy2_q <= SY_IDLE;
    end else begin
      sy1_q <= {scl_i, sda_i, mode_strap, overcurrent_select_strap, chip_enable, uvlo_flag, over_temp,
                oc_trip, reverse_trip, feedback_sense, vout_above_80, vout_below_20, vout_at_target};
      sy2_q <= sy1_q;
    end
  end
  assign {scl_s, sda_s, mode_s, ocps_s, ce_s, uv_s, ot_s, oct_s, rev_s, fb_s, a80_s, b20_s, tgt_s} = sy2_q;

  // Straps need the synchroniser filled, so defaults are reloaded for a few cycles
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      load_q <= STRAP_HOLD;
    end else if (!ce_s) begin
      load_q <= STRAP_HOLD;
    end else if (load_q != 2'h0) begin
      load_q <= load_q - 2'h1;
    end
  end
  assign defaults = !ce_s || (load_q != 2'h0);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= MODE_RST;
      pol_q  <= POL_RST;
    end else if (defaults) begin
      mode_q         <= MODE_RST;
      mode_q[B_FPWM] <= mode_s;
      pol_q          <= POL_RST;
      pol_q[B_OCP]   <= ocps_s;
    end else if (wr_stb) begin
      if (ptr_q == REG_MODE) begin
        mode_q <= sr_q;
      end
      if (ptr_q == REG_POL) begin
        pol_q <= sr_q;
      end
    end
  end

  always_comb begin
    stat        = ZERO8;
    stat[S_PG]  = pg_q;
    stat[S_SS]  = ss_q;
    stat[S_HIC] = hic_q;
    stat[S_TSD] = ot_s;
    stat[S_UV]  = uv_s;
    stat[S_OC]  = oc_q;
  end

  // A continued read fetches the next location ahead of the pointer update
  assign rd_ptr = (st_q == ST_RD) ? ptr_q + 8'h01 : ptr_q;
  always_comb begin
    case (rd_ptr)
      REG_MODE: rd_byte = mode_q;
      REG_POL:  rd_byte = pol_q;
      REG_STAT: rd_byte = stat;
      default:  rd_byte = ZERO8;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end
  assign scl_rise  = scl_s && !scl_d_q;
  assign scl_fall  = !scl_s && scl_d_q;
  assign bus_start = scl_s && scl_d_q && sda_d_q && !sda_s;
  assign bus_stop  = scl_s && scl_d_q && !sda_d_q && sda_s;
  assign wr_stb    = scl_fall && ackph_q && (st_q == ST_WR) && !bus_start && !bus_stop;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q     <= ST_IDLE;
      cnt_q    <= 4'h0;
      ackph_q  <= 1'b0;
      sr_q     <= ZERO8;
      tx_q     <= ZERO8;
      ptr_q    <= ZERO8;
      mack_q   <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (bus_start) begin
      st_q     <= ST_ADDR;
      cnt_q    <= 4'h0;
      ackph_q  <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (bus_stop) begin
      st_q     <= ST_IDLE;
      ackph_q  <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (st_q != ST_IDLE) begin
      if (scl_rise) begin
        if (!ackph_q) begin
          sr_q  <= {sr_q[6:0], sda_s};
          cnt_q <= cnt_q + 4'h1;
        end else begin
          mack_q <= !sda_s;
        end
      end else if (scl_fall) begin
        if (!ackph_q && cnt_q == BYTE_BITS) begin
          ackph_q <= 1'b1;
          case (st_q)
            ST_ADDR: begin
              if (sr_q[7:1] == SLAVE_ADDR) begin
                sda_oe_q <= 1'b1;
              end else begin
                st_q <= ST_IDLE;
              end
            end
            ST_RD:   sda_oe_q <= 1'b0;
            default: sda_oe_q <= 1'b1;
          endcase
        end else if (ackph_q) begin
          ackph_q  <= 1'b0;
          cnt_q    <= 4'h0;
          sda_oe_q <= 1'b0;
          case (st_q)
            ST_ADDR: begin
              if (sr_q[0]) begin
                st_q     <= ST_RD;
                tx_q     <= rd_byte;
                sda_oe_q <= !rd_byte[7];
              end else begin
                st_q <= ST_PTR;
              end
            end
            ST_PTR: begin
              ptr_q <= sr_q;
              st_q  <= ST_WR;
            end
            ST_WR:   ptr_q <= ptr_q + 8'h01;
            ST_RD: begin
              if (mack_q) begin
                ptr_q    <= ptr_q + 8'h01;
                tx_q     <= rd_byte;
                sda_oe_q <= !rd_byte[7];
              end else begin
                st_q <= ST_IDLE;
              end
            end
            default: st_q <= ST_IDLE;
          endcase
        end else if (st_q == ST_RD) begin
          sda_oe_q <= !tx_q[6];
          tx_q     <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end
  assign sda_oe = sda_oe_q;
  assign sda_o  = 1'b0;

  assign run_en  = ce_s && pol_q[B_EN] && !uv_s && !ot_s;
  assign run     = run_en && !hic_q;
  assign us_mode = !mode_q[B_FPWM] && mode_q[B_UMODE];

  // Any stop of the regulator forces a fresh soft-start
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ss_q <= 1'b1;
    end else if (!run) begin
      ss_q <= 1'b1;
    end else if (a80_s) begin
      ss_q <= 1'b0;
    end
  end

  assign pg_lim = pg_q ? PGW'(C_PGF - 1) : PGW'(PG_RISE_CYC - 1);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pg_q  <= 1'b0;
      pgc_q <= '0;
    end else if (ss_q || !run) begin
      pg_q  <= 1'b0;
      pgc_q <= '0;
    end else if (pg_q ? b20_s : tgt_s) begin
      if (pgc_q == pg_lim) begin
        pg_q  <= !pg_q;
        pgc_q <= '0;
      end else begin
        pgc_q <= pgc_q + 1'b1;
      end
    end else begin
      pgc_q <= '0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pg_oe_q <= 1'b1;
    end else begin
      pg_oe_q <= !(pg_q ^ pol_q[B_POL]);
    end
  end
  assign power_good_oe  = pg_oe_q;
  assign power_good_out = 1'b0;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      oc_q  <= 1'b0;
      ocf_q <= '0;
    end else if (!oct_s) begin
      oc_q  <= 1'b0;
      ocf_q <= '0;
    end else if (ocf_q == OFW'(C_OCF - 1)) begin
      oc_q <= 1'b1;
    end else begin
      ocf_q <= ocf_q + 1'b1;
    end
  end

  // Set wins over the cycle boundary clear so no trip is missed
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      oc_seen_q <= 1'b0;
    end else if (oc_q) begin
      oc_seen_q <= 1'b1;
    end else if (cycle_start) begin
      oc_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hic_q  <= 1'b0;
      hcnt_q <= '0;
      occ_q  <= '0;
    end else if (hic_q) begin
      if (hcnt_q == HCW'(HICCUP_CYC - 1)) begin
        hic_q  <= 1'b0;
        hcnt_q <= '0;
      end else begin
        hcnt_q <= hcnt_q + 1'b1;
      end
    end else if (cycle_start) begin
      if (!(oc_seen_q || oc_q)) begin
        occ_q <= '0;
      end else if (occ_q == OCW'(OC_CYCLES - 1)) begin
        hic_q <= 1'b1;
        occ_q <= '0;
      end else begin
        occ_q <= occ_q + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rev_blk_q <= 1'b0;
    end else if (rev_s && mode_q[B_FPWM] && run) begin
      rev_blk_q <= 1'b1;
    end else if (cycle_start) begin
      rev_blk_q <= 1'b0;
    end
  end

  // Idle count holds at its end so pulses repeat while feedback stays high
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      idc_q <= '0;
      upc_q <= '0;
      usp_q <= 1'b0;
    end else if (switch_event || !us_mode || !run) begin
      idc_q <= '0;
      upc_q <= '0;
      usp_q <= 1'b0;
    end else if (usp_q) begin
      if (upc_q == UPW'(C_USP - 1)) begin
        usp_q <= 1'b0;
        upc_q <= '0;
      end else begin
        upc_q <= upc_q + 1'b1;
      end
    end else if (idc_q == IDW'(C_IDLE - 1)) begin
      usp_q <= fb_s;
    end else begin
      idc_q <= idc_q + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      buck_high_switch    <= 1'b0;
      buck_low_switch     <= 1'b0;
      boost_output_switch <= 1'b0;
      boost_ground_switch <= 1'b0;
    end else if (!run) begin
      buck_high_switch    <= 1'b0;
      buck_low_switch     <= 1'b0;
      boost_output_switch <= 1'b0;
      boost_ground_switch <= 1'b0;
    end else begin
      buck_high_switch    <= buck_high_req && !oc_q;
      buck_low_switch     <= (buck_low_req || oc_q || (usp_q && !boost_active)) && !rev_blk_q;
      boost_output_switch <= boost_output_req || (usp_q && boost_active);
      boost_ground_switch <= boost_ground_req && !(usp_q && boost_active);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      regulator_on       <= 1'b0;
      forced_pwm_active  <= 1'b0;
      ultrasonic_active  <= 1'b0;
      freq_reduce        <= 1'b0;
      hiccup_active      <= 1'b0;
      ocp_threshold_high <= 1'b0;
      rise_rate_select   <= 1'b0;
      fall_rate_select   <= 1'b0;
      discharge_on       <= 1'b0;
    end else begin
      regulator_on       <= run;
      forced_pwm_active  <= mode_q[B_FPWM];
      ultrasonic_active  <= us_mode;
      freq_reduce        <= oc_q;
      hiccup_active      <= hic_q;
      ocp_threshold_high <= pol_q[B_OCP];
      rise_rate_select   <= mode_q[B_RISE];
      fall_rate_select   <= mode_q[B_FALL];
      discharge_on       <= mode_q[B_DIS] && !run_en;
    end
  end
  assign soft_start_active = ss_q;
endmodule
`default_nettype wire

// ===== bench/bbc_properties.sv
`timescale 1ns/1ns
`default_nettype none
module bbc_properties #(
  parameter int PG_RISE_CYC = 200,
  parameter int HICCUP_CYC  = 300
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic chip_enable,
  input wire logic uvlo_flag,
  input wire logic over_temp,
  input wire logic oc_trip,
  input wire logic buck_low_req,
  input wire logic scl_i,
  input wire logic sda_oe,
  input wire logic buck_high_switch,
  input wire logic buck_low_switch,
  input wire logic boost_output_switch,
  input wire logic boost_ground_switch,
  input wire logic regulator_on,
  input wire logic soft_start_active,
  input wire logic forced_pwm_active,
  input wire logic ultrasonic_active,
  input wire logic freq_reduce,
  input wire logic hiccup_active,
  input wire logic discharge_on
);
  logic [31:0] hic_n_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hic_n_q <= 32'h0;
    end else begin
      hic_n_q <= hiccup_active ? hic_n_q + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  chk_oc_filter_delay: assert property ($rose(freq_reduce) |-> $past(oc_trip, 10) && $past(oc_trip, 4))
    else $error("current limit honoured too early");
  chk_oc_high_off: assert property (freq_reduce [*2] |-> !buck_high_switch)
    else $error("high switch on during limit");
  chk_hiccup_dark: assert property (hiccup_active [*2] |->
    !(buck_high_switch || buck_low_switch || boost_output_switch || boost_ground_switch))
    else $error("switch on during hiccup");
  // Enable loss does not end a hiccup; only an exit with chip_enable high is timed
  chk_hiccup_length: assert property ($fell(hiccup_active) && chip_enable |-> hic_n_q >= HICCUP_CYC - 1)
    else $error("hiccup too short");
  chk_uvlo_off: assert property (uvlo_flag [*5] |-> !regulator_on)
    else $error("regulator on in lockout");
  chk_thermal_soft: assert property (over_temp [*5] |-> soft_start_active && !regulator_on)
    else $error("regulator on when hot");
  chk_discharge_excl: assert property (regulator_on [*2] |-> !discharge_on)
    else $error("discharge while running");
  chk_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i, 2))
    else $error("data changed with clock high");
  chk_mode_excl: assert property (!(forced_pwm_active && ultrasonic_active))
    else $error("two modes at once");
  chk_usp_width: assert property ($rose(buck_low_switch) && !buck_low_req && ultrasonic_active && !freq_reduce
    |-> buck_low_switch [*5] ##1 !buck_low_switch)
    else $error("ultrasonic pulse width wrong");
endmodule
bind bbc_top bbc_properties #(.PG_RISE_CYC(PG_RISE_CYC), .HICCUP_CYC(HICCUP_CYC)) bbc_properties_inst (.*);
`default_nettype wire

// ===== bench/bbc_i2c_master.sv
`timescale 1ns/1ns
`default_nettype none
module bbc_i2c_master #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic mclk,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Data moves a few cycles after the clock falls, never with it
  task automatic bit_x(input logic b, output logic r);
    hw(4);
    sda_low = !b;
    hw(4);
    scl = 1'b1;
    hw(8);
    r = sda_line;
    scl = 1'b0;
  endtask
  task automatic st;
    hw(4);
    sda_low = 1'b0;
    hw(4);
    scl = 1'b1;
    hw(8);
    sda_low = 1'b1;
    hw(8);
    scl = 1'b0;
  endtask
  task automatic sp;
    hw(4);
    sda_low = 1'b1;
    hw(4);
    scl = 1'b1;
    hw(8);
    sda_low = 1'b0;
    hw(8);
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic k1, k2, k3;
    ok = 1'b0;
    // A refused transfer is tried once more after a pause
    for (int t = 0; t < 2 && !ok; t++) begin
      k2 = 1'b0;
      k3 = 1'b0;
      if (t > 0) hw(16);
      st();
      tx({a, 1'b0}, k1);
      if (k1) begin
        tx(p, k2);
        tx(d, k3);
      end
      sp();
      ok = k1 & k2 & k3;
    end
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic k;
    st();
    tx({ADDR, 1'b0}, k);
    tx(p, k);
    st();
    tx({ADDR, 1'b1}, k);
    rx(1'b1, d);
    sp();
  endtask
endmodule
`default_nettype wire

// ===== bench/bbc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module bbc_top_tb;
  import bbc_pkg::*;
  localparam int PGR = 200;
  localparam int HIC = 300;
  logic mclk, rst_b, chip_enable, mode_strap, overcurrent_select_strap, uvlo_flag, over_temp, oc_trip;
  logic reverse_trip, feedback_sense, vout_above_80, vout_below_20, vout_at_target, scl_i, m_low;
  logic switch_event, cycle_start, boost_active, buck_high_req, buck_low_req, boost_output_req;
  logic boost_ground_req, sda_o, sda_oe, power_good_out, power_good_oe, buck_high_switch;
  logic buck_low_switch, boost_output_switch, boost_ground_switch, regulator_on, soft_start_active;
  logic forced_pwm_active, ultrasonic_active, freq_reduce, hiccup_active, ocp_threshold_high;
  logic rise_rate_select, fall_rate_select, discharge_on, k;
  logic [7:0] d, v;
  logic [31:0] seed;
  int failures, cmp_count, cyc, w;
  // Open-drain line with pull-up: low while either party pulls
  wire sda_i = !(sda_oe || m_low);
  bbc_top #(.PG_RISE_CYC(PGR), .HICCUP_CYC(HIC)) bbc_top_inst (.*);
  bbc_i2c_master #(.ADDR(SLAVE_ADDR_DEF)) bbc_i2c_master_inst (
    .mclk(mclk), .sda_line(sda_i), .scl(scl_i), .sda_low(m_low));
  always #5 mclk = ~mclk;
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [1:0] mode_exp(input logic [7:0] r);
    return {r[B_UMODE] & ~r[B_FPWM], r[B_FPWM]};
  endfunction
  function automatic logic pg_oe(input logic pg, input logic pol);
    return ~(pg ^ pol);
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    mclk = 1'b0;
    {rst_b, uvlo_flag, over_temp, oc_trip, reverse_trip, feedback_sense, vout_above_80, vout_below_20,
     vout_at_target, switch_event, cycle_start, boost_active, buck_high_req, buck_low_req,
     boost_output_req, boost_ground_req} = '0;
    chip_enable = 1'b1;
    seed = nx(32'h8d51);
    mode_strap = seed[0];
    overcurrent_select_strap = seed[1];
    cy(10);
    rst_b = 1'b1;
    cy(10);
    chk(forced_pwm_active, mode_strap);
    chk(ocp_threshold_high, overcurrent_select_strap);
    bbc_i2c_master_inst.rd(REG_POL, d);
    chk(d, POL_RST | {7'h0, overcurrent_select_strap});
    bbc_i2c_master_inst.wr(SLAVE_ADDR_DEF ^ 7'h01, REG_MODE, 8'h41, k);
    chk(k, 1'b0);
    bbc_i2c_master_inst.wr(7'h00, REG_MODE, 8'h41, k);
    chk(k, 1'b0);
    bbc_i2c_master_inst.rd(REG_MODE, d);
    chk(d, {7'h0, mode_strap});
    bbc_i2c_master_inst.rd(8'h7f, d);
    chk(d, ZERO8);
    for (int i = 0; i < 4; i++) begin
      seed = nx(seed);
      v = {1'b0, i[1], 3'h0, seed[2:1], i[0]};
      bbc_i2c_master_inst.wr(SLAVE_ADDR_DEF, REG_MODE, v, k);
      chk(k, 1'b1);
      cy(8);
      chk({ultrasonic_active, forced_pwm_active}, mode_exp(v));
      chk({fall_rate_select, rise_rate_select}, v[2:1]);
      bbc_i2c_master_inst.rd(REG_MODE, d);
      chk(d, v);
    end
    buck_low_req = 1'b1;
    cy(6);
    chk(buck_low_switch, 1'b1);
    reverse_trip = 1'b1;
    cy(1);
    reverse_trip = 1'b0;
    cy(6);
    chk(buck_low_switch, 1'b0);
    cycle_start = 1'b1;
    cy(1);
    cycle_start = 1'b0;
    cy(6);
    chk(buck_low_switch, 1'b1);
    buck_low_req = 1'b0;
    chk(power_good_oe, 1'b1);
    vout_above_80 = 1'b1;
    vout_at_target = 1'b1;
    cy(6);
    chk(soft_start_active, 1'b0);
    cy(PGR - 16);
    chk(power_good_oe, pg_oe(1'b0, 1'b0));
    cy(20);
    chk(power_good_oe, pg_oe(1'b1, 1'b0));
    bbc_i2c_master_inst.wr(SLAVE_ADDR_DEF, REG_POL, POL_RST | 8'h10 | {7'h0, overcurrent_select_strap}, k);
    cy(6);
    chk(power_good_oe, pg_oe(1'b1, 1'b1));
    bbc_i2c_master_inst.wr(SLAVE_ADDR_DEF, REG_POL, POL_RST | {7'h0, overcurrent_select_strap}, k);
    vout_below_20 = 1'b1;
    vout_at_target = 1'b0;
    cy(290);
    chk(power_good_oe, 1'b0);
    cy(PGR + 20);
    chk(power_good_oe, 1'b1);
    chk({sda_o, power_good_out}, 2'b00);
    vout_below_20 = 1'b0;
    vout_at_target = 1'b1;
    cy(PGR + 20);
    chk(power_good_oe, 1'b0);
    over_temp = 1'b1;
    cy(6);
    chk({regulator_on, soft_start_active, power_good_oe}, 3'b011);
    over_temp = 1'b0;
    cy(8);
    chk(regulator_on, 1'b1);
    bbc_i2c_master_inst.wr(SLAVE_ADDR_DEF, REG_MODE, 8'h08, k);
    cy(8);
    chk(discharge_on, 1'b0);
    uvlo_flag = 1'b1;
    cy(6);
    chk({regulator_on, discharge_on}, 2'b01);
    uvlo_flag = 1'b0;
    oc_trip = 1'b1;
    buck_high_req = 1'b1;
    for (int i = 0; i < 25 && hiccup_active !== 1'b1; i++) begin
      cycle_start = 1'b1;
      cy(1);
      cycle_start = 1'b0;
      cy(19);
      if (i == 2) chk({freq_reduce, buck_high_switch}, 2'b10);
    end
    chk(hiccup_active, 1'b1);
    oc_trip = 1'b0;
    cy(HIC - 40);
    chk({hiccup_active, buck_high_switch}, 2'b10);
    cy(60);
    chk(hiccup_active, 1'b0);
    buck_high_req = 1'b0;
    bbc_i2c_master_inst.wr(SLAVE_ADDR_DEF, REG_MODE, 8'h40, k);
    switch_event = 1'b1;
    cy(1);
    switch_event = 1'b0;
    feedback_sense = 1'b1;
    w = 0;
    while (buck_low_switch !== 1'b1 && w < 4000) begin
      cy(1);
      w++;
    end
    // Sync of feedback and output flop allow a few cycles of slack
    chk(8'(w >= 3690 && w <= 3720), 8'h1);
    // Swap to the boost path only in the gap between pulses
    while (buck_low_switch === 1'b1) begin
      cy(1);
    end
    boost_active = 1'b1;
    cy(2);
    chk({boost_output_switch, buck_low_switch}, 2'b10);
    cy(20);
    feedback_sense = 1'b0;
    chip_enable = 1'b0;
    cy(10);
    chip_enable = 1'b1;
    cy(10);
    bbc_i2c_master_inst.rd(REG_MODE, d);
    chk(d, {7'h0, mode_strap});
    wrap_up();
  end
endmodule
`default_nettype wire
